// file: rtl/mrema_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz core clock, 10 Mb/s medium (100 ns bit time)
// Notes:   Definitions only
`ifndef MREMA_CFG_SVH
`define MREMA_CFG_SVH
// Register byte offsets
`define MREMA_RX_EVENT_OFS    5'h00
`define MREMA_RX_CONTROL_OFS  5'h04
`define MREMA_RX_CONFIG_OFS   5'h08
`define MREMA_TX_EVENT_OFS    5'h0c
`define MREMA_TX_COMMAND_OFS  5'h10
`define MREMA_LINE_CONTROL_OFS 5'h14
`define MREMA_TEST_CONTROL_OFS 5'h18
// Field positions
`define MREMA_DRIBBLE_BIT     7
`define MREMA_CRC_BIT         12
`define MREMA_SHORT_BIT       13
`define MREMA_OVERSIZE_BIT    14
`define MREMA_SQE_ERR_BIT     7
`define MREMA_LATE_BIT        9
`define MREMA_COLL_LO         11
`define MREMA_EXCESS_BIT      15
`define MREMA_SINGLE_BIT      9
`define MREMA_AUI_BIT         8
`define MREMA_MOD_BACKOFF_BIT 11
`define MREMA_SIMPLE_DEF_BIT  13
`define MREMA_BACKOFF_DIS_BIT 11
// Reset values
`define MREMA_CTRL_RESET      16'h0000
`define MREMA_LFSR_SEED       16'hace1
// Times in their own units
`define MREMA_CLK_NS          8
`define MREMA_BIT_NS          100
`define MREMA_IPG_NS          9600
`define MREMA_IPG_PART1_NS    6400
// Counts in bit times, then the attempt limit and backoff exponents
`define MREMA_IPG_BITS        (`MREMA_IPG_NS / `MREMA_BIT_NS)
`define MREMA_PART1_BITS      (`MREMA_IPG_PART1_NS / `MREMA_BIT_NS)
`define MREMA_PREAMBLE_BITS   64
`define MREMA_SLOT_BITS       512
`define MREMA_JAM_BITS        32
`define MREMA_SQE_BITS        64
`define MREMA_MAX_ATTEMPTS    16
`define MREMA_BACKOFF_KMAX    10
`define MREMA_MOD_BACKOFF_K   3
// Frame size limits in bytes
`define MREMA_MIN_FRAME       64
`define MREMA_MAX_FRAME       1518
`endif

// file: rtl/mrema_pkg.sv
// Purpose: Types shared by the media access block
// Assumes: Nothing beyond the configuration header
// Notes:   States and result carriers
`default_nettype none
package mrema_pkg;
  typedef enum logic [2:0] {
    ST_DEFER, ST_XMIT, ST_JAM, ST_BACKOFF, ST_SQE
  } mrema_state_e;
  typedef struct packed {
    logic done;
    logic drop;
    logic late;
    logic excess;
  } mrema_tx_res_s;
  typedef struct packed {
    logic valid;
    logic keep;
    logic align_err;
    logic irq_req;
  } mrema_rx_res_s;
endpackage
`default_nettype wire

// file: rtl/mrema_top.sv
// Purpose: Receive error flags and medium access control of a 10 Mb/s MAC
// Assumes: Carrier sense and collision arrive as asynchronous pins
// Notes:   Registers on Avalon-MM, one wait state per access
// Overview of operation
// R01 - Frame under 64 bytes sets short flag; accept keeps it; enable interrupts
// R02 - Frame over 1518 bytes sets oversize flag; accept keeps first 1518
// R03 - Up to seven trailing bits ignored; any sets the dribble flag
// R04 - Dribble plus checksum error on one frame means alignment error
// R05 - Carrier sense active means busy; wait for packet end
// R06 - Simple deferral select clear gives two-part, set gives simple
// R07 - Two-part: activity in first 6.4 us restarts the 9.6 us gap
// R08 - Two-part: after 6.4 us quiet, gap expires despite late activity
// R09 - On gap expiry transmit only if frame pending and not backing off
// R10 - Simple: full 9.6 us gap from carrier drop, no restart
// R11 - Collision in preamble: finish preamble, 32-bit zero jam, backoff
// R12 - Collision before 512 bits: stop data, jam, then backoff
// R13 - Single attempt clear: sixteenth collision sets excessive flag, drops
// R14 - Single attempt set: drop after first normal collision
// R15 - Collision after 512 bits: jam, drop, late flag, no retry
// R16 - After jam wait backoff; modified select picks algorithm
// R17 - Standard: r slots of 512 bits, r up to 2^min(n,10)
// R18 - Modified: k is 3 for n below 3, else min(n,10)
// R19 - Backoff disable: wait only the 9.6 us gap
// R20 - Transceiver answers transmission with 5 to 15 bit test burst
// R21 - Carrier ignored during the post-transmit signal test window
// R22 - Failed checksum sets the checksum error flag
// R23 - Collision count of current frame kept in bits B to E
// R24 - No collision within 64 bits after AUI transmit sets error
// R25 - Free-running LFSR gives random slots; retry count per collision
// R26 - Gaps and backoff counted in 100 ns bit times
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`include "mrema_cfg.svh"
`default_nettype none
module mrema_top
  import mrema_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_crs_pin,
  input  wire logic        i_col_pin,
  input  wire logic        i_tx_pending,
  input  wire logic        i_tx_frame_done,
  output logic             o_tx_start,
  output logic             o_tx_active,
  output logic             o_tx_jam,
  output mrema_tx_res_s    o_tx_result,
  input  wire logic        i_rx_active,
  input  wire logic [10:0] i_rx_byte_count,
  input  wire logic [2:0]  i_rx_extra_bits,
  input  wire logic        i_rx_crc_bad,
  input  wire logic        i_rx_frame_end,
  output logic             o_rx_store_stop,
  output mrema_rx_res_s    o_rx_result
);
  mrema_state_e  state_reg, state_next;
  logic [2:0]    crs_sync_reg, col_sync_reg;
  logic          crs_reg, col_reg, crs_eff;
  logic [6:0]    tick_acc_reg;
  logic          bit_tick;
  logic [15:0]   lfsr_reg;
  logic [6:0]    gap_reg;
  logic [10:0]   ph_reg;
  logic          col_seen_reg, late_reg, retry_reg, sqe_ok_reg;
  logic [4:0]    coll_reg;
  logic [19:0]   bo_reg;
  logic          ack_reg, rd_acc, wr_en;
  logic [15:0]   rx_evt_reg, tx_evt_reg, rx_ctl_reg, rx_cfg_reg;
  logic [15:0]   tx_cmd_reg, line_reg, test_reg;
  logic          start_ok, jam_end, drop_now, excess_now, sqe_end;
  logic [4:0]    coll_next;
  logic          rx_short, rx_over, rx_drib;

  // Random slot count: k from retry count, r limited to 0..2^k
  function automatic logic [10:0] backoff_slots(input logic [4:0] n,
      input logic modified, input logic [15:0] rnd);
    logic [3:0]  k;
    logic [11:0] lim;
    logic [11:0] r;
    k = (n > 5'(`MREMA_BACKOFF_KMAX)) ? 4'(`MREMA_BACKOFF_KMAX)
                                      : n[3:0];             // R17
    if (modified && n < 5'(`MREMA_MOD_BACKOFF_K))
      k = 4'(`MREMA_MOD_BACKOFF_K);                         // R18
    lim = 12'h001 << k;
    r = {1'b0, rnd[10:0]} & ((lim << 1) - 12'h001);
    if (r > lim)
      r = r - lim;
    return r[10:0];
  endfunction

  // Three-stage synchronisers; a change counts once stages 2 and 3 agree
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      crs_sync_reg <= 3'h0;
      col_sync_reg <= 3'h0;
      crs_reg      <= 1'b0;
      col_reg      <= 1'b0;
    end else begin
      crs_sync_reg <= {crs_sync_reg[1:0], i_crs_pin};
      col_sync_reg <= {col_sync_reg[1:0], i_col_pin};
      if (crs_sync_reg[1] == crs_sync_reg[2])
        crs_reg <= crs_sync_reg[2];
      if (col_sync_reg[1] == col_sync_reg[2])
        col_reg <= col_sync_reg[2];
    end
  end

  // Bit-time tick: 12.5 clocks on average, exact over two bits
  always_ff @(posedge i_clock) begin
    if (i_reset)
      tick_acc_reg <= 7'h00;
    else if (bit_tick)
      tick_acc_reg <= tick_acc_reg + 7'(`MREMA_CLK_NS)
                      - 7'(`MREMA_BIT_NS);                  // R26
    else
      tick_acc_reg <= tick_acc_reg + 7'(`MREMA_CLK_NS);
  end
  assign bit_tick = (tick_acc_reg + 7'(`MREMA_CLK_NS))
                    >= 7'(`MREMA_BIT_NS);

  // Free-running random source at the bit rate
  always_ff @(posedge i_clock) begin
    if (i_reset)
      lfsr_reg <= `MREMA_LFSR_SEED;
    else if (bit_tick)
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13]
                   ^ lfsr_reg[12] ^ lfsr_reg[10]};          // R25
  end

  // Carrier is masked in the signal test window
  assign crs_eff = crs_reg && (state_reg != ST_SQE);        // R21

  // Inter-packet gap timer
  always_ff @(posedge i_clock) begin
    if (i_reset)
      gap_reg <= 7'h00;
    else if (state_reg == ST_XMIT || state_reg == ST_JAM)
      gap_reg <= 7'h00;
    else if (crs_eff && (gap_reg == 7'(`MREMA_IPG_BITS)
             || (line_reg[`MREMA_SIMPLE_DEF_BIT] ? gap_reg == 7'h00
             : gap_reg < 7'(`MREMA_PART1_BITS))))          // R06 R07 R10
      gap_reg <= 7'h00;                                     // R05
    else if (bit_tick && gap_reg != 7'(`MREMA_IPG_BITS))
      gap_reg <= gap_reg + 7'h01;                           // R08
  end

  assign start_ok = (state_reg == ST_DEFER) && i_tx_pending
                    && gap_reg == 7'(`MREMA_IPG_BITS);     // R09 R10
  assign jam_end = (state_reg == ST_JAM) && bit_tick
                   && ph_reg == 11'(`MREMA_JAM_BITS - 1);
  assign coll_next = coll_reg + 5'h01;                      // R25
  assign excess_now = coll_next == 5'(`MREMA_MAX_ATTEMPTS);
  assign drop_now = late_reg || excess_now
                    || tx_cmd_reg[`MREMA_SINGLE_BIT];       // R13 R14 R15
  assign sqe_end = (state_reg == ST_SQE) && bit_tick
                   && ph_reg == 11'(`MREMA_SQE_BITS - 1);   // R21

  // Transmit sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_DEFER:
        if (start_ok)
          state_next = ST_XMIT;
      ST_XMIT:
        if ((col_reg || col_seen_reg)
            && ph_reg >= 11'(`MREMA_PREAMBLE_BITS))         // R11 R12
          state_next = ST_JAM;
        else if (i_tx_frame_done)
          state_next = line_reg[`MREMA_AUI_BIT] ? ST_SQE : ST_DEFER;
      ST_JAM:
        if (jam_end)
          state_next = (drop_now || test_reg[`MREMA_BACKOFF_DIS_BIT])
                       ? ST_DEFER : ST_BACKOFF;             // R15 R19
      ST_BACKOFF:
        if (bo_reg == 20'h00000)
          state_next = ST_DEFER;                            // R16
      ST_SQE:
        if (sqe_end)
          state_next = ST_DEFER;
      default:
        state_next = ST_DEFER;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset)
      state_reg <= ST_DEFER;
    else
      state_reg <= state_next;
  end

  // Phase counter in bit times, cleared on every state change
  always_ff @(posedge i_clock) begin
    if (i_reset || state_next != state_reg)
      ph_reg <= 11'h000;
    else if (bit_tick && ph_reg != 11'h7ff)
      ph_reg <= ph_reg + 11'h001;
  end

  // Collision seen during preamble, and late marking at jam entry
  always_ff @(posedge i_clock) begin
    if (i_reset || state_reg != ST_XMIT)
      col_seen_reg <= 1'b0;
    else if (col_reg)
      col_seen_reg <= 1'b1;                                 // R11
  end

  always_ff @(posedge i_clock) begin
    if (i_reset)
      late_reg <= 1'b0;
    else if (state_reg == ST_XMIT && state_next == ST_JAM)
      late_reg <= ph_reg >= 11'(`MREMA_SLOT_BITS);          // R15
  end

  // Retry count of the current frame
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      coll_reg  <= 5'h00;
      retry_reg <= 1'b0;
    end else if (start_ok && !retry_reg) begin
      coll_reg  <= 5'h00;
      retry_reg <= 1'b1;
    end else if (jam_end) begin
      if (!late_reg)
        coll_reg <= coll_next;                              // R23
      retry_reg <= !drop_now;
    end else if (state_reg == ST_XMIT && i_tx_frame_done
                 && state_next != ST_JAM)
      retry_reg <= 1'b0;
  end

  // Backoff delay in bit times, loaded at jam end
  always_ff @(posedge i_clock) begin
    if (i_reset)
      bo_reg <= 20'h00000;
    else if (jam_end)
      bo_reg <= {backoff_slots(coll_next,
                 line_reg[`MREMA_MOD_BACKOFF_BIT], lfsr_reg),
                 9'h000};                                   // R16 R17 R18
    else if (state_reg == ST_BACKOFF && bit_tick && bo_reg != 20'h00000)
      bo_reg <= bo_reg - 20'h00001;
  end

  // Collision answer seen within the test window
  always_ff @(posedge i_clock) begin
    if (i_reset || state_reg != ST_SQE)
      sqe_ok_reg <= 1'b0;
    else if (col_reg)
      sqe_ok_reg <= 1'b1;                                   // R24
  end

  // Transmit outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_tx_result <= '0;
      o_tx_active <= 1'b0;
      o_tx_jam    <= 1'b0;
    end else begin
      o_tx_result.done   <= state_reg == ST_XMIT && i_tx_frame_done
                            && state_next != ST_JAM;
      o_tx_result.drop   <= jam_end && drop_now;
      o_tx_result.late   <= jam_end && late_reg;
      o_tx_result.excess <= jam_end && !late_reg && excess_now;
      o_tx_active <= state_next == ST_XMIT;
      o_tx_jam    <= state_next == ST_JAM;                  // R12
    end
  end
  assign o_tx_start = start_ok;

  // Receive checks at frame end
  assign rx_short = i_rx_byte_count < 11'(`MREMA_MIN_FRAME);
  assign rx_over  = i_rx_byte_count > 11'(`MREMA_MAX_FRAME);
  assign rx_drib  = i_rx_extra_bits != 3'h0;                // R03

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rx_result     <= '0;
      o_rx_store_stop <= 1'b0;
    end else begin
      o_rx_result.valid <= i_rx_frame_end;
      o_rx_result.keep  <= i_rx_frame_end
        && !(rx_short && !rx_ctl_reg[`MREMA_SHORT_BIT])     // R01
        && !(rx_over && !rx_ctl_reg[`MREMA_OVERSIZE_BIT]);  // R02
      o_rx_result.align_err <= i_rx_frame_end && rx_drib
                               && i_rx_crc_bad;             // R04
      o_rx_result.irq_req <= i_rx_frame_end
        && ((rx_short && rx_cfg_reg[`MREMA_SHORT_BIT])
        || (rx_over && rx_cfg_reg[`MREMA_OVERSIZE_BIT]));
      o_rx_store_stop <= i_rx_active
        && i_rx_byte_count >= 11'(`MREMA_MAX_FRAME);        // R02
    end
  end

  // Avalon slave: one wait state, read data loads on the first edge, write at the edge where ack is high
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
  assign rd_acc = i_avs_read && !ack_reg;
  assign wr_en  = i_avs_write && ack_reg;

  always_ff @(posedge i_clock) begin
    if (i_reset)
      ack_reg <= 1'b0;
    else
      ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset)
      o_avs_readdata <= 32'h00000000;
    else if (rd_acc) begin
      case (i_avs_address)
        `MREMA_RX_EVENT_OFS:     o_avs_readdata <= {16'h0000, rx_evt_reg};
        `MREMA_RX_CONTROL_OFS:   o_avs_readdata <= {16'h0000, rx_ctl_reg};
        `MREMA_RX_CONFIG_OFS:    o_avs_readdata <= {16'h0000, rx_cfg_reg};
        `MREMA_TX_EVENT_OFS:     o_avs_readdata <= {16'h0000, tx_evt_reg};
        `MREMA_TX_COMMAND_OFS:   o_avs_readdata <= {16'h0000, tx_cmd_reg};
        `MREMA_LINE_CONTROL_OFS: o_avs_readdata <= {16'h0000, line_reg};
        `MREMA_TEST_CONTROL_OFS: o_avs_readdata <= {16'h0000, test_reg};
        default:                 o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Control registers, only documented bits are writable
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_ctl_reg <= `MREMA_CTRL_RESET;
      rx_cfg_reg <= `MREMA_CTRL_RESET;
      tx_cmd_reg <= `MREMA_CTRL_RESET;
      line_reg   <= `MREMA_CTRL_RESET;
      test_reg   <= `MREMA_CTRL_RESET;
    end else if (wr_en) begin
      case (i_avs_address)
        `MREMA_RX_CONTROL_OFS:   rx_ctl_reg <= i_avs_writedata[15:0]
                                               & 16'h6000;
        `MREMA_RX_CONFIG_OFS:    rx_cfg_reg <= i_avs_writedata[15:0]
                                               & 16'h6000;
        `MREMA_TX_COMMAND_OFS:   tx_cmd_reg <= i_avs_writedata[15:0]
                                               & 16'h0200;
        `MREMA_LINE_CONTROL_OFS: line_reg   <= i_avs_writedata[15:0]
                                               & 16'h2900;
        `MREMA_TEST_CONTROL_OFS: test_reg   <= i_avs_writedata[15:0]
                                               & 16'h0800;
        default: ;
      endcase
    end
  end

  // Event flags: write one to clear, a new event wins over the clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_evt_reg <= 16'h0000;
      tx_evt_reg <= 16'h0000;
    end else begin
      if (wr_en && i_avs_address == `MREMA_RX_EVENT_OFS)
        rx_evt_reg <= rx_evt_reg & ~i_avs_writedata[15:0];
      if (i_rx_frame_end) begin
        if (rx_short)
          rx_evt_reg[`MREMA_SHORT_BIT] <= 1'b1;             // R01
        if (rx_over)
          rx_evt_reg[`MREMA_OVERSIZE_BIT] <= 1'b1;          // R02
        if (rx_drib)
          rx_evt_reg[`MREMA_DRIBBLE_BIT] <= 1'b1;           // R03
        if (i_rx_crc_bad)
          rx_evt_reg[`MREMA_CRC_BIT] <= 1'b1;               // R22
      end
      if (wr_en && i_avs_address == `MREMA_TX_EVENT_OFS)
        tx_evt_reg <= tx_evt_reg & ~(i_avs_writedata[15:0] & 16'h8280);
      tx_evt_reg[`MREMA_COLL_LO +: 4] <= coll_reg[3:0];     // R23
      if (jam_end && late_reg)
        tx_evt_reg[`MREMA_LATE_BIT] <= 1'b1;                // R15
      if (jam_end && !late_reg && excess_now)
        tx_evt_reg[`MREMA_EXCESS_BIT] <= 1'b1;              // R13
      if (sqe_end && !col_reg && !sqe_ok_reg)
        tx_evt_reg[`MREMA_SQE_ERR_BIT] <= 1'b1;             // R24
    end
  end

  // Checks
  sequence jam_run_s;
    (state_reg == ST_JAM) [*8];
  endsequence
  gap_start_a: assert property (@(posedge i_clock) disable iff (i_reset) // R09
    o_tx_start |-> gap_reg == 7'(`MREMA_IPG_BITS) && i_tx_pending)
    else $error("start without full gap");
  jam_hold_a: assert property (@(posedge i_clock) disable iff (i_reset) // R11
    $rose(state_reg == ST_JAM) |-> jam_run_s)
    else $error("jam too short");
  pre_finish_a: assert property (@(posedge i_clock) disable iff (i_reset) // R11
    state_reg == ST_XMIT && state_next == ST_JAM
    |-> ph_reg >= 11'(`MREMA_PREAMBLE_BITS))
    else $error("jam inside preamble");
  late_nobo_a: assert property (@(posedge i_clock) disable iff (i_reset) // R15
    jam_end && late_reg |=> state_reg == ST_DEFER
    && tx_evt_reg[`MREMA_LATE_BIT])
    else $error("late collision backed off");
  bo_disable_a: assert property (@(posedge i_clock) disable iff (i_reset) // R19
    jam_end && test_reg[`MREMA_BACKOFF_DIS_BIT] |=> state_reg != ST_BACKOFF)
    else $error("backoff despite disable");
  single_drop_a: assert property (@(posedge i_clock) disable iff (i_reset) // R14
    jam_end && tx_cmd_reg[`MREMA_SINGLE_BIT] |=> o_tx_result.drop)
    else $error("single attempt not dropped");
  sqe_mask_a: assert property (@(posedge i_clock) disable iff (i_reset) // R21
    state_reg == ST_SQE && $past(state_reg) == ST_SQE && gap_reg != 7'h00
    |=> gap_reg != 7'h00)
    else $error("carrier not masked in test window");
  short_flag_a: assert property (@(posedge i_clock) disable iff (i_reset) // R01
    i_rx_frame_end && rx_short |=> rx_evt_reg[`MREMA_SHORT_BIT]
    ##1 rx_evt_reg[`MREMA_SHORT_BIT] || $past(wr_en))
    else $error("short flag missing");
  excess_flag_a: assert property (@(posedge i_clock) disable iff (i_reset) // R13
    jam_end && !late_reg && coll_reg == 5'h0f |=> o_tx_result.excess
    && o_tx_result.drop)
    else $error("sixteenth collision not dropped");
  align_a: assert property (@(posedge i_clock) disable iff (i_reset) // R04
    i_rx_frame_end && rx_drib && i_rx_crc_bad |=> o_rx_result.align_err)
    else $error("alignment error missed");
endmodule // mrema_top
`default_nettype wire

// file: tb/mrema_medium.sv
// Purpose: Codec and shared medium stand-in for the media access bench
// Assumes: Bench asks for carrier and collision by level
// Notes:   Test burst follows each transmit that ends without jam, when enabled
`default_nettype none
module mrema_medium (
  input  wire logic i_clock,
  input  wire logic i_tx_active,
  input  wire logic i_tx_jam,
  input  wire logic i_crs_req,
  input  wire logic i_col_req,
  input  wire logic i_sqe_en,
  output logic      o_crs,
  output logic      o_col
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       act_reg;
  logic [8:0] sqe_reg;
  wire logic  burst = (sqe_reg > 9'h07d);
  // Burst of 10 bit times starting 1 us after transmit ends
  always_ff @(posedge i_clock) begin
    act_reg <= i_tx_active;
    if (act_reg && !i_tx_active && !i_tx_jam && i_sqe_en) begin
      sqe_reg <= 9'h001;
    end else if (sqe_reg != 9'h000 && sqe_reg < 9'h0fa) begin
      sqe_reg <= sqe_reg + 9'h001;
    end else begin
      sqe_reg <= 9'h000;
    end
  end
  // Collision only while our station sends, or as the test burst
  assign o_col = (i_col_req & (i_tx_active | i_tx_jam)) | burst;
  assign o_crs = i_crs_req | burst;
endmodule // mrema_medium
`default_nettype wire

// file: tb/mrema_top_bench.sv
// Purpose: Self-checking bench for receive flags and medium access
// Assumes: Avalon answers after one wait state; 125 MHz clock
// Notes:   Expected results queue up; a monitor pops and compares
`default_nettype none
module mrema_top_bench import mrema_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0, i_reset = 1'b1, rd = 1'b0, wr = 1'b0;
  logic pend = 1'b0, fdone = 1'b0, rxa = 1'b0, crc = 1'b0, fend = 1'b0;
  logic crs_req = 1'b0, col_req = 1'b0, sqe_en = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0, rdata, m;
  logic [10:0] cnt = 11'h000;
  logic [2:0]  xb = 3'h0;
  logic wait_r, start, active, jam, stop, crs, col;
  mrema_tx_res_s txr;
  mrema_rx_res_s rxr;
  logic [31:0] eq[$], mq[$], rxq[$], txq[$];
  int err_total = 0, checks = 0, a, b, n;
  // Clock at 125 MHz
  always #4 i_clock = ~i_clock;
  mrema_top dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_crs_pin(crs), .i_col_pin(col),
    .i_tx_pending(pend), .i_tx_frame_done(fdone), .o_tx_start(start),
    .o_tx_active(active), .o_tx_jam(jam), .o_tx_result(txr),
    .i_rx_active(rxa), .i_rx_byte_count(cnt), .i_rx_extra_bits(xb),
    .i_rx_crc_bad(crc), .i_rx_frame_end(fend), .o_rx_store_stop(stop),
    .o_rx_result(rxr));
  mrema_medium peer (.i_clock(i_clock), .i_tx_active(active),
    .i_tx_jam(jam), .i_crs_req(crs_req), .i_col_req(col_req),
    .i_sqe_en(sqe_en), .o_crs(crs), .o_col(col));
  task automatic cmp(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Monitor pops the oldest note whenever a result shows
  always @(posedge i_clock) begin
    if (rd && wait_r === 1'b0) begin
      m = mq.pop_front();
      cmp("readdata", eq.pop_front() & m, rdata & m);
    end
    if (rxr.valid === 1'b1)
      cmp("rx_result", rxq.pop_front(), {28'h0, rxr});
    if (|{txr.drop, txr.late, txr.excess}) begin
      cmp("tx_result", txq.pop_front(),
          {29'h0, txr.drop, txr.late, txr.excess});
    end
  end
  // One Avalon access; a read notes its expected word and mask
  task automatic bus(input logic w, input logic [4:0] ad,
                     input logic [31:0] d, mk);
    @(posedge i_clock);
    adr <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    if (!w) begin
      eq.push_back(d);
      mq.push_back(mk);
    end
    @(posedge i_clock iff wait_r === 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rx(input logic [10:0] c, input logic [2:0] x,
                    input logic bad, input logic [3:0] r);
    @(posedge i_clock);
    rxa <= 1'b1;
    cnt <= c;
    xb <= x;
    crc <= bad;
    repeat (3) @(posedge i_clock);
    if (c > 11'd1518) cmp("store_stop", 32'h1, {31'h0, stop});
    rxq.push_back({28'h0, r});
    fend <= 1'b1;
    @(posedge i_clock);
    fend <= 1'b0;
    rxa <= 1'b0;
  endtask
  task automatic wait_start(output int k);
    k = 0;
    while (start !== 1'b1 && k < 40000) begin
      @(posedge i_clock);
      k++;
    end
  endtask
  task automatic finish_frame();
    pend <= 1'b0;
    repeat (50) @(posedge i_clock);
    cmp("tx_active", 32'h1, {31'h0, active});
    fdone <= 1'b1;
    @(posedge i_clock);
    fdone <= 1'b0;
    @(posedge i_clock);
    cmp("tx_done", 32'h1, {31'h0, txr.done});
  endtask
  task automatic send();
    pend <= 1'b1;
    wait_start(n);
    finish_frame();
    repeat (1000) @(posedge i_clock);
  endtask
  // Long carrier burst, frame pending at its end, second burst at cycle p
  task automatic gap(input int p, input int lo);
    int k;
    crs_req <= 1'b1;
    repeat (1300) @(posedge i_clock);
    crs_req <= 1'b0;
    pend <= 1'b1;
    k = 0;
    while (start !== 1'b1 && k < 4000) begin
      @(posedge i_clock);
      k++;
      if (k == p) crs_req <= 1'b1;
      if (k == p + 30) crs_req <= 1'b0;
    end
    cmp("gap_cycles", 32'h1, {31'h0, (k >= lo && k <= lo + 70)});
    finish_frame();
  endtask
  task automatic coll(input int d, output int pa, pb, pn);
    pend <= 1'b1;
    wait_start(pn);
    repeat (d) @(posedge i_clock);
    col_req <= 1'b1;
    pa = 0;
    pb = 0;
    while (jam !== 1'b1 && pa < 9000) begin
      @(posedge i_clock);
      pa++;
    end
    while (jam === 1'b1 && pb < 900) begin
      @(posedge i_clock);
      pb++;
    end
    col_req <= 1'b0;
  endtask
  // Main sequence
  initial begin
    n = $urandom(32'h56003043);
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int i = 0; i < 32; i += 4) bus(0, 5'(i), 32'h0, 32'hffffffff);
    bus(1, 5'h04, 32'h6000, 32'h0);
    bus(1, 5'h08, 32'h6000, 32'h0);
    bus(1, 5'h1c, 32'hffff, 32'h0);
    bus(0, 5'h04, 32'h6000, 32'hffffffff);
    bus(0, 5'h1c, 32'h0, 32'hffffffff);
    rx(11'd63, 3'd0, 1'b0, 4'hd);
    rx(11'd1519, 3'd0, 1'b0, 4'hd);
    rx(11'd1518, 3'd0, 1'b0, 4'hc);
    rx(11'd100, 3'd3, 1'b1, 4'he);
    rx(11'd64 + 11'($urandom % 1455), 3'($urandom), 1'b0, 4'hc);
    bus(0, 5'h00, 32'h7080, 32'hffff);
    bus(1, 5'h00, 32'h7080, 32'h0);
    bus(0, 5'h00, 32'h0, 32'hffff);
    bus(1, 5'h14, 32'h0100, 32'h0);
    sqe_en <= 1'b1;
    send();
    bus(0, 5'h0c, 32'h0, 32'h0080);
    sqe_en <= 1'b0;
    send();
    bus(0, 5'h0c, 32'h0080, 32'h0080);
    bus(1, 5'h0c, 32'h0080, 32'h0);
    bus(1, 5'h14, 32'h0, 32'h0);
    gap(400, 1600);
    gap(900, 1170);
    bus(1, 5'h14, 32'h2000, 32'h0);
    gap(400, 1170);
    bus(1, 5'h14, 32'h0, 32'h0);
    bus(1, 5'h10, 32'h0200, 32'h0);
    txq.push_back(32'h4);
    coll(0, a, b, n);
    pend <= 1'b0;
    cmp("pre_jam", 32'h1, {31'h0, (a >= 780 && a <= 830)});
    cmp("jam_len", 32'h1, {31'h0, (b >= 385 && b <= 415)});
    bus(1, 5'h10, 32'h0, 32'h0);
    txq.push_back(32'h6);
    coll(7000, a, b, n);
    pend <= 1'b0;
    cmp("late_jam", 32'h1, {31'h0, (a <= 10)});
    bus(0, 5'h0c, 32'h0200, 32'h0200);
    bus(1, 5'h0c, 32'h0200, 32'h0);
    txq.push_back(32'h5);
    coll(2000, a, b, n);
    cmp("mid_jam", 32'h1, {31'h0, (a <= 10)});
    for (int i = 0; i < 15; i++) begin
      if (i == 0) bus(1, 5'h18, 32'h0800, 32'h0);
      coll(0, a, b, n);
      if (i == 0) cmp("backoff", 32'h1, {31'h0, (n <= 14030)});
      if (i == 2) cmp("no_backoff", 32'h1, {31'h0, (n <= 1260)});
    end
    pend <= 1'b0;
    repeat (20) @(posedge i_clock);
    bus(0, 5'h0c, 32'h8000, 32'h8000);
    repeat (5) @(posedge i_clock);
    cmp("notes_left", 32'h0, 32'(eq.size() + rxq.size() + txq.size()));
    print_verdict();
  end
  // Watchdog cuts a hang short
  initial begin
    #720000;
    err_total++;
    print_verdict();
  end
endmodule // mrema_top_bench
`default_nettype wire
